// ---- hw/lcdi_slave.sv ----
// Write-only two-wire serial slave front end of a segment display driver.
// Assumes SCL and SDA pins well below the 100 MHz clock, straps held steady.
`timescale 1ns/10ps
`include "lcdi_defs.svh"

module lcdi_slave #(
    parameter int FIFO_DEPTH = `LCDI_FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output      logic       sda_out,
    output      logic       sda_oe_n,
    input  wire logic       addr_select_pin,
    input  wire logic       hw_subaddr_pin_0,
    input  wire logic       hw_subaddr_pin_1,
    input  wire logic       hw_subaddr_pin_2,
    output      logic       disp_valid,
    input  wire logic       disp_ready,
    output      logic [7:0] disp_data,
    output      logic [6:0] disp_ptr,
    output      logic [2:0] disp_sub,
    output      logic       cmd_valid,
    output      logic [7:0] cmd_byte,
    output      logic [6:0] data_ptr,
    output      logic [2:0] subaddr,
    output      logic       addressed
);

    localparam int FW = 18;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic       scl_meta_r;
    logic       scl_s_r;
    logic       scl_d_r;
    logic       sda_meta_r;
    logic       sda_s_r;
    logic       sda_d_r;
    logic [3:0] strap_meta_r;
    logic [3:0] strap_s_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_meta_r <= 1'b1;
            scl_s_r    <= 1'b1;
            scl_d_r    <= 1'b1;
            sda_meta_r <= 1'b1;
            sda_s_r    <= 1'b1;
            sda_d_r    <= 1'b1;
        end else begin
            scl_meta_r <= scl_in;
            scl_s_r    <= scl_meta_r;
            scl_d_r    <= scl_s_r;
            sda_meta_r <= sda_in;
            sda_s_r    <= sda_meta_r;
            sda_d_r    <= sda_s_r;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_meta_r <= 4'h0;
            strap_s_r    <= 4'h0;
        end else begin
            strap_meta_r <= {addr_select_pin, hw_subaddr_pin_2, hw_subaddr_pin_1, hw_subaddr_pin_0};
            strap_s_r    <= strap_meta_r;
        end
    end

    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       sel_level;
    logic [2:0] hw_sub;

    assign scl_rise   = scl_s_r && !scl_d_r;
    assign scl_fall   = !scl_s_r && scl_d_r;
    assign start_cond = scl_s_r && scl_d_r && !sda_s_r && sda_d_r;
    assign stop_cond  = scl_s_r && scl_d_r && sda_s_r && !sda_d_r;
    assign sel_level  = strap_s_r[3];
    assign hw_sub     = strap_s_r[2:0];

    // ----------------------------------------
    // Byte decoders
    // ----------------------------------------
    function automatic logic addr_hit(input logic [7:0] b, input logic sel);
        addr_hit = (b[7:2] == `LCDI_ADDR_PREFIX) && (b[`LCDI_ADDR_SEL_BIT] == sel);
    endfunction

    function automatic logic is_devsel(input logic [7:0] b);
        is_devsel = (b[7:3] == `LCDI_DEVSEL_CODE);
    endfunction

    function automatic logic is_ldptr(input logic [7:0] b);
        is_ldptr = !b[`LCDI_LDPTR_BIT];
    endfunction

    // ----------------------------------------
    // Bit engine and parser
    // ----------------------------------------
    lcdi_pkg::lcdi_state_t state_r;
    logic [7:0]            shift_r;
    logic [3:0]            bit_cnt_r;
    logic                  in_ack_r;
    logic                  continue_flag_r;
    logic                  payload_select_flag_r;
    logic                  sda_oe_n_r;
    logic [6:0]            data_ptr_r;
    logic [2:0]            subaddr_r;
    logic                  cmd_valid_r;
    logic [7:0]            cmd_byte_r;
    logic                  addressed_r;
    logic                  fifo_ready;
    logic                  fifo_push;
    logic [FW-1:0]         fifo_out;

    logic                  byte_done;
    logic                  disp_byte;
    logic                  cmd_byte_hit;

    // Last bit sampled and the falling edge closes the byte
    assign byte_done    = scl_fall && !in_ack_r && (bit_cnt_r == `LCDI_BITS_PER_BYTE);
    assign disp_byte    = byte_done && (state_r == lcdi_pkg::ST_PAY) && payload_select_flag_r;
    assign cmd_byte_hit = byte_done && (state_r == lcdi_pkg::ST_PAY) && !payload_select_flag_r;
    assign fifo_push    = disp_byte && (subaddr_r == hw_sub);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_r   <= 8'h00;
            bit_cnt_r <= 4'h0;
            in_ack_r  <= 1'b0;
        end else if (start_cond || stop_cond) begin
            bit_cnt_r <= 4'h0;
            in_ack_r  <= 1'b0;
        end else if (scl_rise && !in_ack_r && bit_cnt_r != `LCDI_BITS_PER_BYTE) begin
            shift_r   <= {shift_r[6:0], sda_s_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (byte_done) begin
            in_ack_r  <= 1'b1;
        end else if (scl_fall && in_ack_r) begin
            in_ack_r  <= 1'b0;
            bit_cnt_r <= 4'h0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r               <= lcdi_pkg::ST_IDLE;
            continue_flag_r       <= 1'b0;
            payload_select_flag_r <= 1'b0;
        end else if (start_cond) begin
            state_r <= lcdi_pkg::ST_ADDR;
        end else if (stop_cond) begin
            state_r <= lcdi_pkg::ST_IDLE;
        end else if (byte_done) begin
            case (state_r)
                lcdi_pkg::ST_ADDR: begin
                    if (addr_hit(shift_r, sel_level) && !shift_r[`LCDI_ADDR_RW_BIT]) begin
                        state_r <= lcdi_pkg::ST_CTRL;
                    end else begin
                        state_r <= lcdi_pkg::ST_IGN;
                    end
                end
                lcdi_pkg::ST_CTRL: begin
                    continue_flag_r       <= shift_r[`LCDI_CTRL_CONT_BIT];
                    payload_select_flag_r <= shift_r[`LCDI_CTRL_DEST_BIT];
                    state_r               <= lcdi_pkg::ST_PAY;
                end
                lcdi_pkg::ST_PAY: begin
                    if (continue_flag_r) begin
                        state_r <= lcdi_pkg::ST_CTRL;
                    end
                end
                lcdi_pkg::ST_IGN: begin
                    state_r <= lcdi_pkg::ST_IGN;
                end
                default: begin
                    state_r <= lcdi_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addressed_r <= 1'b0;
        end else if (start_cond || stop_cond) begin
            addressed_r <= 1'b0;
        end else if (byte_done && state_r == lcdi_pkg::ST_ADDR) begin
            addressed_r <= addr_hit(shift_r, sel_level) && !shift_r[`LCDI_ADDR_RW_BIT];
        end
    end

    // ----------------------------------------
    // Acknowledge driver
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_oe_n_r <= 1'b1;
        end else if (start_cond || stop_cond) begin
            sda_oe_n_r <= 1'b1;
        end else if (byte_done) begin
            case (state_r)
                lcdi_pkg::ST_ADDR: begin
                    sda_oe_n_r <= !(addr_hit(shift_r, sel_level) && !shift_r[`LCDI_ADDR_RW_BIT]);
                end
                lcdi_pkg::ST_CTRL: begin
                    sda_oe_n_r <= 1'b0;
                end
                lcdi_pkg::ST_PAY: begin
                    // display byte acked only on matching subaddress with FIFO room
                    if (payload_select_flag_r) begin
                        sda_oe_n_r <= !((subaddr_r == hw_sub) && fifo_ready);
                    end else begin
                        sda_oe_n_r <= 1'b0;
                    end
                end
                default: begin
                    sda_oe_n_r <= 1'b1;
                end
            endcase
        end else if (scl_fall && in_ack_r) begin
            sda_oe_n_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Data pointer and subaddress counter
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_ptr_r <= `LCDI_PTR_RST;
            subaddr_r  <= `LCDI_SUB_RST;
        end else if (cmd_byte_hit && is_devsel(shift_r)) begin
            subaddr_r  <= shift_r[2:0];
        end else if (cmd_byte_hit && is_ldptr(shift_r)) begin
            data_ptr_r <= shift_r[6:0];
        end else if (disp_byte) begin
            if (data_ptr_r >= `LCDI_PTR_LAST) begin
                data_ptr_r <= `LCDI_PTR_RST;
                subaddr_r  <= subaddr_r + 3'h1;
            end else begin
                data_ptr_r <= data_ptr_r + 7'h01;
            end
        end
    end

    // ----------------------------------------
    // Command strobe to the decoder
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_valid_r <= 1'b0;
            cmd_byte_r  <= 8'h00;
        end else begin
            cmd_valid_r <= cmd_byte_hit;
            if (cmd_byte_hit) begin
                cmd_byte_r <= shift_r;
            end
        end
    end

    // ----------------------------------------
    // Display write queue
    // ----------------------------------------
    // byte tagged with pointer and subaddress
    lcdi_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) lcdi_fifo_i (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (fifo_push),
        .in_ready  (fifo_ready),
        .in_data   ({shift_r, data_ptr_r, subaddr_r}),
        .out_valid (disp_valid),
        .out_ready (disp_ready),
        .out_data  (fifo_out)
    );

    assign disp_data = fifo_out[17:10];
    assign disp_ptr  = fifo_out[9:3];
    assign disp_sub  = fifo_out[2:0];

    // only ever pulls the line low
    assign sda_out   = 1'b0;
    assign sda_oe_n  = sda_oe_n_r;
    assign cmd_valid = cmd_valid_r;
    assign cmd_byte  = cmd_byte_r;
    assign data_ptr  = data_ptr_r;
    assign subaddr   = subaddr_r;
    assign addressed = addressed_r;

endmodule // lcdi_slave

// ---- hw/lcdi_defs.svh ----
// Constants of the write-only display driver serial slave.
// Assumes inclusion by bare name from the design files.
`ifndef LCDI_DEFS_SVH
`define LCDI_DEFS_SVH

// ----------------------------------------
// Slave address byte
// ----------------------------------------
`define LCDI_ADDR_PREFIX     6'h1c
`define LCDI_ADDR_SEL_BIT    1
`define LCDI_ADDR_RW_BIT     0

// ----------------------------------------
// Control byte fields
// ----------------------------------------
`define LCDI_CTRL_CONT_BIT   7
`define LCDI_CTRL_DEST_BIT   6

// ----------------------------------------
// Command encodings
// ----------------------------------------
`define LCDI_DEVSEL_CODE     5'h1c
`define LCDI_LDPTR_BIT       7

// ----------------------------------------
// Pointer limits, reset values and sizes
// ----------------------------------------
`define LCDI_PTR_LAST        7'h3b
`define LCDI_PTR_RST         7'h00
`define LCDI_SUB_RST         3'h0
`define LCDI_FIFO_DEPTH      4
`define LCDI_BITS_PER_BYTE   4'h8

`endif

// ---- hw/lcdi_pkg.sv ----
// Types of the display driver serial slave.
// Assumes nothing of its surroundings.
package lcdi_pkg;

    // ----------------------------------------
    // Parser states
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_CTRL = 5'b00100,
        ST_PAY  = 5'b01000,
        ST_IGN  = 5'b10000
    } lcdi_state_t;

endpackage

// ---- hw/lcdi_fifo.sv ----
// Small shift FIFO with a registered head word.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/10ps

module lcdi_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);

    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [CW-1:0]    cnt_r;
    logic [CW-1:0]    cnt_nxt;
    logic [CW-1:0]    wr_idx;
    logic             full_r;
    logic             valid_r;
    logic             push;
    logic             pop;

    assign push      = in_valid && !full_r;
    assign pop       = out_ready && valid_r;
    assign in_ready  = !full_r;
    assign out_valid = valid_r;
    assign out_data  = mem_r[0];
    assign wr_idx    = pop ? cnt_r - CW'(1) : cnt_r;

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + CW'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    // ----------------------------------------
    // Storage, head always in slot 0
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (push && wr_idx == CW'(i)) begin
                    mem_r[i] <= in_data;
                end else if (pop && i < DEPTH - 1) begin
                    mem_r[i] <= mem_r[i+1];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r   <= '0;
            full_r  <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            full_r  <= (cnt_nxt == CW'(DEPTH));
            valid_r <= (cnt_nxt != '0);
        end
    end

endmodule // lcdi_fifo

// ---- testbench/lcdi_asserts.sv ----
// Checker of the display driver serial slave.
// Assumes binding to lcdi_slave, one clock domain.
`timescale 1ns/10ps

module lcdi_asserts #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       addr_select_pin,
    input wire logic       hw_subaddr_pin_0,
    input wire logic       hw_subaddr_pin_1,
    input wire logic       hw_subaddr_pin_2,
    input wire logic       disp_valid,
    input wire logic       disp_ready,
    input wire logic [7:0] disp_data,
    input wire logic [6:0] disp_ptr,
    input wire logic [2:0] disp_sub,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic [6:0] data_ptr,
    input wire logic [2:0] subaddr,
    input wire logic       addressed
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_ack_held;
        !sda_oe_n [*8];
    endsequence
    sequence s_stop_seen;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    property p_out_low;
        sda_out == 1'b0;
    endproperty
    property p_ack_held;
        $fell(sda_oe_n) |-> s_ack_held;
    endproperty
    property p_ack_scl_low;
        $fell(sda_oe_n) |-> !scl_in;
    endproperty
    property p_cmd_pulse;
        cmd_valid |=> !cmd_valid;
    endproperty
    property p_cmd_addr;
        cmd_valid |-> addressed;
    endproperty
    property p_sub_load;
        cmd_valid && cmd_byte[7:3] == 5'h1c |-> ##[0:1] subaddr == cmd_byte[2:0];
    endproperty
    property p_ptr_load;
        cmd_valid && !cmd_byte[7] |-> ##[0:1] data_ptr == cmd_byte[6:0];
    endproperty
    property p_disp_sub;
        $rose(disp_valid) |-> disp_sub == {hw_subaddr_pin_2, hw_subaddr_pin_1, hw_subaddr_pin_0};
    endproperty
    property p_ptr_adv;
        $rose(disp_valid) |-> ##[0:2] data_ptr == ((disp_ptr == 7'h3b) ? 7'h00 : disp_ptr + 7'h01);
    endproperty
    property p_stop_clr;
        s_stop_seen |-> ##[1:4] !addressed;
    endproperty

    a_out_low: assert property (p_out_low) else $error("data pin driven high");
    a_ack_held: assert property (p_ack_held) else $error("ack slot too short");
    a_ack_scl_low: assert property (p_ack_scl_low) else $error("ack started with SCL high");
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe too long");
    a_cmd_addr: assert property (p_cmd_addr) else $error("command while not addressed");
    a_sub_load: assert property (p_sub_load) else $error("subaddress not loaded");
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
    a_disp_sub: assert property (p_disp_sub) else $error("byte stored for other subaddress");
    a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance");
    a_stop_clr: assert property (p_stop_clr) else $error("still addressed after stop");
endmodule // lcdi_asserts

bind lcdi_slave lcdi_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) lcdi_asserts_i (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_select_pin(addr_select_pin), .hw_subaddr_pin_0(hw_subaddr_pin_0),
    .hw_subaddr_pin_1(hw_subaddr_pin_1), .hw_subaddr_pin_2(hw_subaddr_pin_2), .disp_valid(disp_valid),
    .disp_ready(disp_ready), .disp_data(disp_data), .disp_ptr(disp_ptr), .disp_sub(disp_sub),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .data_ptr(data_ptr), .subaddr(subaddr),
    .addressed(addressed));

// ---- testbench/lcdi_mstr_model.sv ----
// Two-wire bus master model for the display slave.
// Assumes a pull-up on SDA resolved by the bench.
`timescale 1ns/10ps

module lcdi_mstr_model (
    input  wire logic clk,
    input  wire logic sda_in,
    output      logic scl,
    output      logic sda_m
);
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    // Quarter of a 160 ns SCL period
    task automatic q();
        repeat (4) @(negedge clk);
    endtask

    task automatic start();
        q();
        sda_m = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_m = 1'b0;
        q();
        scl = 1'b0;
    endtask

    task automatic stop();
        q();
        sda_m = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_m = 1'b1;
        q();
    endtask

    // Data moves only while SCL is low
    task automatic put_bit(input logic v, output logic s);
        q();
        sda_m = v;
        q();
        scl = 1'b1;
        q();
        s = sda_in;
        q();
        scl = 1'b0;
    endtask

    // Eight bits MSB first, ninth clock for ack
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
    endtask
endmodule // lcdi_mstr_model

// ---- testbench/lcdi_slave_bench.sv ----
// Self-checking bench of the display driver serial slave.
// Assumes the master model and checker are compiled first.
`timescale 1ns/10ps

module lcdi_slave_bench;
    logic       clk;
    logic       sys_rst;
    logic       scl;
    logic       sda_m;
    wire logic  sda;
    logic       sda_out;
    logic       sda_oe_n;
    logic       sel;
    logic [2:0] pins;
    logic       disp_valid;
    logic       disp_ready;
    logic [7:0] disp_data;
    logic [6:0] disp_ptr;
    logic [2:0] disp_sub;
    logic       cmd_valid;
    logic [7:0] cmd_byte;
    logic [6:0] data_ptr;
    logic [2:0] subaddr;
    logic       addressed;
    logic       ack;
    int         failures;
    int         tests_run;

    // Open drain with pull-up
    assign sda = sda_m & (sda_oe_n | sda_out);

    lcdi_slave #(.FIFO_DEPTH(4)) lcdi_slave_i (
        .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_select_pin(sel), .hw_subaddr_pin_0(pins[0]), .hw_subaddr_pin_1(pins[1]),
        .hw_subaddr_pin_2(pins[2]), .disp_valid(disp_valid), .disp_ready(disp_ready), .disp_data(disp_data),
        .disp_ptr(disp_ptr), .disp_sub(disp_sub), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .data_ptr(data_ptr), .subaddr(subaddr), .addressed(addressed));

    lcdi_mstr_model lcdi_mstr_model_i (.clk(clk), .sda_in(sda), .scl(scl), .sda_m(sda_m));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic sb(input logic [7:0] b, input logic e);
        lcdi_mstr_model_i.put_byte(b, ack);
        chk({7'h00, ack}, {7'h00, e});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({7'h00, sda_oe_n}, 8'h01);
        chk({1'b0, data_ptr}, 8'h00);
        chk({5'h00, subaddr}, 8'h00);
        chk({7'h00, disp_valid}, 8'h00);
    endtask

    task automatic t_addr();
        logic [7:0] a;
        logic       e;
        for (int s = 0; s < 2; s++) begin
            sel = s[0];
            for (int k = 0; k < 5; k++) begin
                a = (k == 4) ? 8'hf0 : {6'h1c, k[1:0]};
                e = (a[7:2] == 6'h1c) && (a[1] == sel) && !a[0];
                lcdi_mstr_model_i.start();
                sb(a, e);
                if (!e)
                    sb(8'h00, 1'b0);
                chk({7'h00, addressed}, {7'h00, e});
                lcdi_mstr_model_i.stop();
            end
        end
    endtask

    task automatic t_write();
        sel = 1'b0;
        pins = 3'h3;
        lcdi_mstr_model_i.start();
        sb(8'h70, 1'b1);
        sb(8'h80, 1'b1);
        sb(8'h05, 1'b1);
        chk({1'b0, data_ptr}, 8'h05);
        sb(8'hbf, 1'b1);
        sb(8'he3, 1'b1);
        chk({5'h00, subaddr}, 8'h03);
        chk(cmd_byte, 8'he3);
        sb(8'h40, 1'b1);
        for (int i = 0; i < 5; i++)
            sb(8'ha0 + i[7:0], i < 4);
        chk({1'b0, data_ptr}, 8'h0a);
        for (int i = 0; i < 4; i++) begin
            chk({7'h00, disp_valid}, 8'h01);
            chk(disp_data, 8'ha0 + i[7:0]);
            chk({1'b0, disp_ptr}, 8'h05 + i[7:0]);
            chk({5'h00, disp_sub}, 8'h03);
            disp_ready = 1'b1;
            @(negedge clk);
            disp_ready = 1'b0;
            @(negedge clk);
        end
        chk({7'h00, disp_valid}, 8'h00);
    endtask

    task automatic t_wrap();
        lcdi_mstr_model_i.start();
        sb(8'h70, 1'b1);
        sb(8'h80, 1'b1);
        sb(8'h3b, 1'b1);
        sb(8'h40, 1'b1);
        sb(8'h55, 1'b1);
        chk({1'b0, data_ptr}, 8'h00);
        chk({5'h00, subaddr}, 8'h04);
        chk({1'b0, disp_ptr}, 8'h3b);
        sb(8'h66, 1'b0);
        chk({1'b0, data_ptr}, 8'h01);
        chk(disp_data, 8'h55);
        lcdi_mstr_model_i.stop();
    endtask

    task automatic t_cont();
        lcdi_mstr_model_i.start();
        sb(8'h70, 1'b1);
        sb(8'h80, 1'b1);
        sb(8'he3, 1'b1);
        sb(8'hc0, 1'b1);
        sb(8'h77, 1'b1);
        sb(8'h00, 1'b1);
        sb(8'h10, 1'b1);
        chk({1'b0, data_ptr}, 8'h10);
        chk(cmd_byte, 8'h10);
        lcdi_mstr_model_i.stop();
        disp_ready = 1'b1;
        @(negedge clk);
        disp_ready = 1'b0;
        chk(disp_data, 8'h77);
        chk({1'b0, disp_ptr}, 8'h01);
        chk({5'h00, disp_sub}, 8'h03);
    endtask

    task automatic t_part();
        lcdi_mstr_model_i.start();
        sb(8'h70, 1'b1);
        for (int i = 0; i < 4; i++)
            lcdi_mstr_model_i.put_bit(1'b0, ack);
        lcdi_mstr_model_i.start();
        sb(8'h70, 1'b1);
        lcdi_mstr_model_i.stop();
        chk({7'h00, addressed}, 8'h00);
    endtask

    initial begin
        failures = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        sel = 1'b0;
        pins = 3'h0;
        disp_ready = 1'b0;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_addr();
        t_write();
        t_wrap();
        t_cont();
        t_part();
        close_out();
    end

    initial begin
        repeat (50000) @(posedge clk);
        failures++;
        close_out();
    end
endmodule // lcdi_slave_bench
